/* ppf_pkg.sv */
/*
 * ppf_pkg: shared constants of the printer port with output FIFO.
 * Assumes a single clock domain and a byte-wide host register file.
 */
package ppf_pkg;

    // host register offsets (A1:A0)
    localparam logic [1:0] PPF_OFS_DATA = 2'h0;
    localparam logic [1:0] PPF_OFS_STAT = 2'h1;
    localparam logic [1:0] PPF_OFS_CTRL = 2'h2;
    localparam logic [1:0] PPF_OFS_ALT = 2'h3;

    // port_control bit positions
    localparam int PPF_CB_STROBE = 0;
    localparam int PPF_CB_AUTO = 1;
    localparam int PPF_CB_INIT = 2;
    localparam int PPF_CB_CHOOSE = 3;
    localparam int PPF_CB_IRQ_EN = 4;
    localparam int PPF_CB_DIR = 5;

    // alt_function bit positions
    localparam int PPF_AB_TSEL_HI = 2;
    localparam int PPF_AB_HS_BUSY = 3;
    localparam int PPF_AB_ITYPE_LO = 4;
    localparam int PPF_AB_ITYPE_HI = 5;
    localparam int PPF_AB_POL = 6;
    localparam int PPF_AB_FIFO_EN = 7;

    // interrupt types
    localparam logic [1:0] PPF_IT_NORMAL = 2'h0;
    localparam logic [1:0] PPF_IT_EMPTY = 2'h1;
    localparam logic [1:0] PPF_IT_FULL = 2'h2;
    localparam logic [1:0] PPF_IT_EMPTY0 = 2'h3;

    // direction_select codes
    localparam logic [7:0] PPF_DIR_IN_CODE = 8'haa;
    localparam logic [7:0] PPF_DIR_OUT_CODE = 8'h55;

    // reset values
    localparam logic [7:0] PPF_CTRL_RST = 8'h00;
    localparam logic [7:0] PPF_ALT_RST = 8'h00;
    localparam logic [7:0] PPF_BUS_RST = 8'hff;

    // fifo geometry
    localparam int PPF_FIFO_DEPTH = 83;
    localparam int PPF_CNT_W = 7;

    // strobe delay / width in clocks, indexed by timing select
    localparam logic [7:0][4:0] PPF_TSD = {5'h09, 5'h05, 5'h05, 5'h03,
                                           5'h12, 5'h0a, 5'h0a, 5'h06};
    localparam logic [7:0][4:0] PPF_TSW = {5'h08, 5'h04, 5'h04, 5'h02,
                                           5'h10, 5'h08, 5'h08, 5'h04};

    typedef enum logic [4:0] {
        PPF_ENG_IDLE = 5'h01,
        PPF_ENG_DELAY = 5'h02,
        PPF_ENG_PULSE = 5'h04,
        PPF_ENG_WAIT = 5'h08,
        PPF_ENG_HOLD = 5'h10
    } ppf_eng_t;

endpackage

/* ppf_fifo_mem.sv */
/*
 * ppf_fifo_mem: simple dual-port byte store with a registered read port.
 * Assumes the caller keeps addresses in range and manages occupancy.
 */
`timescale 1ns/1ps
module ppf_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 83,
    parameter int AW = 7
) (
    // clock and control
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // read port
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            store[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= '0;
        end else if (ce_i && rd_en_i) begin
            rd_data_o <= store[rd_addr_i];
        end
    end
endmodule // ppf_fifo_mem

/* ppf_skid.sv */
/*
 * ppf_skid: two-entry buffer with valid/ready on both sides.
 * Assumes one clock; clr_i empties it in one cycle.
 */
`timescale 1ns/1ps
module ppf_skid #(
    parameter int WIDTH = 8
) (
    // clock and control
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic clr_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] slot1;
    logic [1:0] fill;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (fill != 2'h2);
    assign out_valid_o = (fill != 2'h0);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || (ce_i && clr_i)) begin
            fill <= 2'h0;
            out_data_o <= '0;
            slot1 <= '0;
        end else if (ce_i) begin
            if (push && pop) begin
                out_data_o <= (fill == 2'h1) ? in_data_i : slot1;
                slot1 <= in_data_i;
            end else if (pop) begin
                out_data_o <= slot1;
                fill <= fill - 2'h1;
            end else if (push) begin
                if (fill == 2'h0) begin
                    out_data_o <= in_data_i;
                end else begin
                    slot1 <= in_data_i;
                end
                fill <= fill + 2'h1;
            end
        end
    end
endmodule // ppf_skid

/* ppf_port.sv */
/*
 * ppf_port: printer-style parallel port with an 83-byte output FIFO,
 * host register file on A1:A0 with read and write strobes.
 * Assumes all pins synchronous to clk_i; open-drain pins are modelled as
 * plain outputs, the irq pin as output plus enable.
 */
`timescale 1ns/1ps
// Function
// - init asserted leaves fifo mode, strobe held high
// - fifo mode after first strobe and reply
// - fifo mode strobes automatically, bit0 ignored
// - timing select sets strobe delay, width
// - alt bit3 picks done or busy handshake
// - one fifo read per handshake falling edge
// - count tracks writes and reads, 2 clocks
// - write to full fifo is dropped
// - latched irq set by bit0, status read clears
// - nonlatched irq cleared by next port write
// - status bit6 nonlatched (normal type), bit2 done pending
// - alt bit6 inverts irq polarity
// - alt bits5:4 choose interrupt type
// - status bit7 not busy, or fifo not full when enabled
// - bit2 pends on done fall, read clears
// - status low bits and live input levels
// - control readback shows pin levels
// - control drives pins, irq enable, direction
// - alt bit7 enables fifo, default off
// - fifo_count shows count and disabled flag
// - direction by control bit5 or select codes
// - reset: bus out high, init low
// - reset or init change clears fifo
// - init low: port reads drain, strobe high
module ppf_port
    import ppf_pkg::*;
#(
    parameter int DEPTH = PPF_FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // host register bus
    input wire logic [1:0] host_addr_i,
    input wire logic host_wr_n_i,
    input wire logic host_rd_n_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    // straps
    input wire logic irq_style_pin_i,
    input wire logic dir_hw_select_i,
    // printer data bus
    input wire logic [7:0] printer_bus_i,
    output logic [7:0] printer_bus_o,
    output logic printer_bus_oe_o,
    // printer controls
    output logic print_pulse_n_o,
    output logic auto_line_advance_n_o,
    output logic printer_reset_out_n_o,
    output logic printer_choose_n_o,
    output logic printer_irq_n_o,
    output logic printer_irq_oe_o,
    // printer status
    input wire logic printer_done_n_i,
    input wire logic busy_i,
    input wire logic error_i,
    input wire logic printer_online_i,
    input wire logic paper_out_i
);
    logic wr_q, rd_q;
    logic [7:0] ctrl, alt, bus;
    logic dir_sel_in, init_q, fifo_mode, armed;
    logic nl_irq, lat_irq, irq_pend;
    logic done_q, done_d, busy_q, busy_d;
    logic [PPF_CNT_W-1:0] byte_cnt, mem_cnt, wr_ptr, rd_ptr;
    logic rd_pend;
    ppf_eng_t eng;
    logic [4:0] tcnt;
    logic [PPF_CNT_W-1:0] next_byte_cnt;
    logic irq_act;
    logic [7:0] stat_word, rb_word, rd_mux;

    // host strobe decode: act once, on the leading edge of each strobe
    wire wr_start = wr_q && !host_wr_n_i;
    wire rd_start = rd_q && !host_rd_n_i;
    wire wr_data = wr_start && (host_addr_i == PPF_OFS_DATA);
    wire wr_dsel = wr_start && (host_addr_i == PPF_OFS_STAT);
    wire wr_ctrl = wr_start && (host_addr_i == PPF_OFS_CTRL);
    wire wr_alt = wr_start && (host_addr_i == PPF_OFS_ALT);
    wire rd_data = rd_start && (host_addr_i == PPF_OFS_DATA);
    wire rd_stat = rd_start && (host_addr_i == PPF_OFS_STAT);

    wire init_lvl = ctrl[PPF_CB_INIT];
    wire init_chg = init_lvl != init_q;
    wire fifo_en = alt[PPF_AB_FIFO_EN];
    wire [1:0] itype = alt[PPF_AB_ITYPE_HI:PPF_AB_ITYPE_LO];
    wire [2:0] tsel = alt[PPF_AB_TSEL_HI:0];
    // two-stage edge detect puts count settling at two clocks
    wire done_fall = done_d && !done_q;
    wire busy_fall = busy_d && !busy_q;
    wire hs_fall = alt[PPF_AB_HS_BUSY] ? busy_fall : done_fall;
    wire fifo_path = fifo_en && (fifo_mode || !init_lvl);
    wire full = (byte_cnt == PPF_CNT_W'(DEPTH));
    wire empty = fifo_en && (byte_cnt == '0);
    wire push_ok = wr_data && fifo_path && !full;
    wire fifo_clr = init_chg;
    wire dir_in = dir_hw_select_i ? ctrl[PPF_CB_DIR] : dir_sel_in;

    wire mem_rd;
    wire [7:0] mem_q;
    wire sk_in_ready, sk_valid;
    wire [7:0] sk_data;
    wire eng_take = (eng == PPF_ENG_IDLE) && sk_valid && fifo_path && !fifo_clr;
    wire hs_take = (eng == PPF_ENG_WAIT) && hs_fall;
    wire rd_take = (eng == PPF_ENG_HOLD) && rd_data;
    wire dec = hs_take || rd_take;

    assign mem_rd = (mem_cnt != '0) && !rd_pend && sk_in_ready && !fifo_clr;

    ppf_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(PPF_CNT_W)) u_mem (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .wr_en_i(push_ok),
        .wr_addr_i(wr_ptr),
        .wr_data_i(host_data_i),
        .rd_en_i(mem_rd),
        .rd_addr_i(rd_ptr),
        .rd_data_o(mem_q)
    );

    // buffer lets the strobe engine stall without losing a fetched byte
    ppf_skid #(.WIDTH(8)) u_skid (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .clr_i(fifo_clr),
        .in_valid_i(rd_pend),
        .in_ready_o(sk_in_ready),
        .in_data_i(mem_q),
        .out_valid_o(sk_valid),
        .out_ready_i(eng_take),
        .out_data_o(sk_data)
    );

    // host register writes and strobe history
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            ctrl <= PPF_CTRL_RST;
            alt <= PPF_ALT_RST;
            dir_sel_in <= 1'b0;
            init_q <= PPF_CTRL_RST[PPF_CB_INIT];
        end else if (ce_i) begin
            wr_q <= host_wr_n_i;
            rd_q <= host_rd_n_i;
            init_q <= init_lvl;
            if (wr_ctrl) begin
                ctrl <= host_data_i;
            end
            if (wr_alt) begin
                alt <= host_data_i;
            end
            if (wr_dsel && host_data_i == PPF_DIR_IN_CODE) begin
                dir_sel_in <= 1'b1;
            end else if (wr_dsel && host_data_i == PPF_DIR_OUT_CODE) begin
                dir_sel_in <= 1'b0;
            end
        end
    end

    // handshake sampling
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b1;
            done_d <= 1'b1;
            busy_q <= 1'b0;
            busy_d <= 1'b0;
        end else if (ce_i) begin
            done_q <= printer_done_n_i;
            done_d <= done_q;
            busy_q <= busy_i;
            busy_d <= busy_q;
        end
    end

    // mode entry: a manual strobe armed, then the printer answers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fifo_mode <= 1'b0;
            armed <= 1'b0;
        end else if (ce_i) begin
            if (init_chg || !init_lvl || !fifo_en) begin
                fifo_mode <= 1'b0;
                armed <= 1'b0;
            end else if (armed && (done_fall || busy_fall)) begin
                fifo_mode <= 1'b1;
                armed <= 1'b0;
            end else if (wr_ctrl && host_data_i[PPF_CB_STROBE] && !fifo_mode) begin
                armed <= 1'b1;
            end
        end
    end

    // byte counter follows host writes and printer takes
    always_comb begin
        next_byte_cnt = byte_cnt;
        if (push_ok && !dec) begin
            next_byte_cnt = byte_cnt + PPF_CNT_W'(1);
        end else if (dec && !push_ok && byte_cnt != '0) begin
            next_byte_cnt = byte_cnt - PPF_CNT_W'(1);
        end
    end

    // memory pointers wrap at the fifo depth
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || (ce_i && fifo_clr)) begin
            byte_cnt <= '0;
            mem_cnt <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            rd_pend <= 1'b0;
        end else if (ce_i) begin
            byte_cnt <= next_byte_cnt;
            rd_pend <= mem_rd;
            if (push_ok) begin
                wr_ptr <= (wr_ptr == PPF_CNT_W'(DEPTH - 1)) ? '0 : wr_ptr + PPF_CNT_W'(1);
            end
            if (mem_rd) begin
                rd_ptr <= (rd_ptr == PPF_CNT_W'(DEPTH - 1)) ? '0 : rd_ptr + PPF_CNT_W'(1);
            end
            if (push_ok && !mem_rd) begin
                mem_cnt <= mem_cnt + PPF_CNT_W'(1);
            end else if (mem_rd && !push_ok) begin
                mem_cnt <= mem_cnt - PPF_CNT_W'(1);
            end
        end
    end

    // strobe engine: load byte, wait delay, pulse, wait for handshake
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eng <= PPF_ENG_IDLE;
            tcnt <= '0;
            bus <= PPF_BUS_RST;
        end else if (ce_i) begin
            if (wr_data && !fifo_path) begin
                bus <= host_data_i;
            end
            if (fifo_clr) begin
                eng <= PPF_ENG_IDLE;
            end else begin
                case (eng)
                    PPF_ENG_IDLE: begin
                        if (eng_take) begin
                            bus <= sk_data;
                            tcnt <= PPF_TSD[tsel] - 5'h01;
                            eng <= init_lvl ? PPF_ENG_DELAY : PPF_ENG_HOLD;
                        end
                    end
                    PPF_ENG_DELAY: begin
                        if (tcnt == '0) begin
                            tcnt <= PPF_TSW[tsel] - 5'h01;
                            eng <= PPF_ENG_PULSE;
                        end else begin
                            tcnt <= tcnt - 5'h01;
                        end
                    end
                    PPF_ENG_PULSE: begin
                        if (tcnt == '0) begin
                            eng <= PPF_ENG_WAIT;
                        end else begin
                            tcnt <= tcnt - 5'h01;
                        end
                    end
                    PPF_ENG_WAIT: begin
                        if (hs_fall) begin
                            eng <= PPF_ENG_IDLE;
                        end
                    end
                    PPF_ENG_HOLD: begin
                        if (rd_data) begin
                            eng <= PPF_ENG_IDLE;
                        end
                    end
                    default: begin
                        eng <= PPF_ENG_IDLE;
                    end
                endcase
            end
        end
    end

    // interrupt sources; a set in the same cycle as a clear wins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            nl_irq <= 1'b0;
            lat_irq <= 1'b0;
            irq_pend <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl && host_data_i[PPF_CB_STROBE]) begin
                nl_irq <= 1'b1;
                lat_irq <= 1'b1;
            end else begin
                if (wr_data) begin
                    nl_irq <= 1'b0;
                end
                if (rd_stat) begin
                    lat_irq <= 1'b0;
                end
            end
            if (done_fall) begin
                irq_pend <= 1'b1;
            end else if (rd_stat) begin
                irq_pend <= 1'b0;
            end
        end
    end

    // interrupt type selects what drives the pin
    always_comb begin
        case (itype)
            PPF_IT_NORMAL: irq_act = irq_style_pin_i ? lat_irq : nl_irq;
            PPF_IT_FULL: irq_act = fifo_en && full;
            default: irq_act = empty;
        endcase
    end

    assign printer_irq_n_o = !(irq_act ^ alt[PPF_AB_POL]);
    assign printer_irq_oe_o = ctrl[PPF_CB_IRQ_EN];

    // pins: init low holds strobe high, fifo mode ignores bit0
    // init low wins at once, even in the cycle before fifo mode drops
    assign print_pulse_n_o = !init_lvl || (fifo_mode ? (eng != PPF_ENG_PULSE)
                           : !ctrl[PPF_CB_STROBE]);
    assign auto_line_advance_n_o = !ctrl[PPF_CB_AUTO];
    assign printer_reset_out_n_o = ctrl[PPF_CB_INIT];
    assign printer_choose_n_o = !ctrl[PPF_CB_CHOOSE];
    assign printer_bus_o = bus;
    assign printer_bus_oe_o = !dir_in;

    // read words
    assign stat_word = {fifo_en ? !full : !busy_i,
                        (itype == PPF_IT_NORMAL) ? !nl_irq
                            : ((itype == PPF_IT_FULL) ? fifo_en && full : empty),
                        paper_out_i, printer_online_i, error_i,
                        !irq_pend,
                        (itype == PPF_IT_EMPTY0) ? 2'h0 : 2'h3};
    assign rb_word = {3'h7, ctrl[PPF_CB_IRQ_EN], !printer_choose_n_o,
                      printer_reset_out_n_o, !auto_line_advance_n_o, !print_pulse_n_o};
    assign rd_mux = (host_addr_i == PPF_OFS_DATA) ? (dir_in ? printer_bus_i : bus)
                  : (host_addr_i == PPF_OFS_STAT) ? stat_word
                  : (host_addr_i == PPF_OFS_CTRL) ? rb_word
                  : {!fifo_en, byte_cnt};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_data_o <= '0;
        end else if (ce_i) begin
            host_data_o <= rd_mux;
        end
    end

    assign host_data_oe_o = !host_rd_n_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !ce_i);

    sequence s_strobe_ends;
        (eng == PPF_ENG_PULSE) ##1 (eng == PPF_ENG_WAIT);
    endsequence

    init_leave_a: assert property (init_chg |=> !fifo_mode)
        else $error("fifo mode survived an init change");
    mode_entry_a: assert property ($rose(fifo_mode) |-> $past(armed))
        else $error("fifo mode entered without an armed strobe");
    auto_strobe_a: assert property (fifo_mode && eng != PPF_ENG_PULSE
        |-> print_pulse_n_o)
        else $error("strobe low outside the pulse phase");
    pulse_width_a: assert property ($rose(eng == PPF_ENG_PULSE) && tsel == 3'h4
        |-> (eng == PPF_ENG_PULSE)[*2] ##1 (eng == PPF_ENG_WAIT))
        else $error("strobe width wrong for select 100");
    strobe_end_a: assert property (s_strobe_ends |-> $past(tcnt) == '0)
        else $error("pulse ended before its count ran out");
    count_dec_a: assert property (hs_take && !push_ok && byte_cnt != '0 && !fifo_clr
        |=> byte_cnt == $past(byte_cnt) - PPF_CNT_W'(1))
        else $error("count did not drop after a printer take");
    full_drop_a: assert property (wr_data && full && !dec && !fifo_clr
        |=> byte_cnt == $past(byte_cnt))
        else $error("write to a full fifo changed the count");
    nl_clear_a: assert property (wr_data && !wr_ctrl |=> !nl_irq)
        else $error("non-latched irq not cleared by a port write");
    pend_clear_a: assert property (rd_stat && !done_fall |=> !irq_pend)
        else $error("status read did not clear the pending flag");
    init_strobe_a: assert property (!init_lvl |-> print_pulse_n_o)
        else $error("strobe driven while init is low");
    dir_sel_a: assert property (dir_hw_select_i && ctrl[PPF_CB_DIR]
        |-> !printer_bus_oe_o)
        else $error("bus driven in input mode");
endmodule // ppf_port

/* ppf_printer_model.sv */
/* ppf_printer_model: printer on the far side of the port.
   assumes the port pins are sampled on rising clk_i edges. */
`timescale 1ns/1ps
module ppf_printer_model (
    // port side
    input wire logic clk_i,
    input wire logic print_pulse_n_i,
    input wire logic [7:0] printer_bus_i,
    // test control
    input wire logic stall_i,
    // handshake back to the port
    output logic printer_done_n_o,
    output logic busy_o
);
    logic [7:0] rx [0:15];
    logic [3:0] n_rx = 4'h0;
    logic [7:0] width = 8'h0;
    logic [3:0] wait_cnt = 4'h0;
    logic pend = 1'b0;
    logic last_n = 1'b1;
    initial begin
        printer_done_n_o = 1'b1;
        busy_o = 1'b0;
    end
    always @(posedge clk_i) begin
        last_n <= print_pulse_n_i;
        if (!print_pulse_n_i && last_n) begin
            rx[n_rx] <= printer_bus_i;
            n_rx <= n_rx + 4'h1;
            width <= 8'h1;
            busy_o <= 1'b1;
            pend <= 1'b1;
        end else if (!print_pulse_n_i) begin
            width <= width + 8'h1;
        end else if (pend && !stall_i) begin
            // reply only after the strobe ends; stall holds the byte unacknowledged
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == 4'h3) begin
                printer_done_n_o <= 1'b0;
            end
            if (wait_cnt == 4'h6) begin
                printer_done_n_o <= 1'b1;
                busy_o <= 1'b0;
                pend <= 1'b0;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule // ppf_printer_model

/* test_ppf_port.sv */
/* test_ppf_port: self-checking bench for ppf_port with a printer model.
   assumes ppf_pkg, ppf_port and ppf_printer_model are compiled first. */
`timescale 1ns/1ps
module test_ppf_port;
    import ppf_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, host_wr_n_i = 1, host_rd_n_i = 1, stall = 0, ce = 1;
    logic irq_style_pin_i = 0, dir_hw_select_i = 1, error_i = 1, online = 0, pout = 1;
    logic [1:0] host_addr_i = 2'h0;
    logic [7:0] host_data_i = 8'h0, d;
    logic [3:0] n0;
    int num_errors = 0, num_checks = 0;
    wire [7:0] host_data_o, bus_o, bus_i;
    wire hoe, bus_oe, pulse_n, auto_n, rst_n, choose_n, irq_n, irq_oe, done_n, busy;
    // input mode sees a fixed pattern, not the byte the port last drove
    assign bus_i = bus_oe ? bus_o : 8'h3c;
    always #12.5 clk_i = ~clk_i;
    ppf_port DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .host_addr_i(host_addr_i), .host_wr_n_i(host_wr_n_i), .host_rd_n_i(host_rd_n_i),
        .host_data_i(host_data_i), .host_data_o(host_data_o), .host_data_oe_o(hoe),
        .irq_style_pin_i(irq_style_pin_i), .dir_hw_select_i(dir_hw_select_i),
        .printer_bus_i(bus_i), .printer_bus_o(bus_o), .printer_bus_oe_o(bus_oe),
        .print_pulse_n_o(pulse_n), .auto_line_advance_n_o(auto_n),
        .printer_reset_out_n_o(rst_n), .printer_choose_n_o(choose_n),
        .printer_irq_n_o(irq_n), .printer_irq_oe_o(irq_oe), .printer_done_n_i(done_n),
        .busy_i(busy), .error_i(error_i), .printer_online_i(online), .paper_out_i(pout));
    ppf_printer_model printer (.clk_i(clk_i), .print_pulse_n_i(pulse_n),
        .printer_bus_i(bus_i), .stall_i(stall), .printer_done_n_o(done_n), .busy_o(busy));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(negedge clk_i);
        host_addr_i = a;
        host_data_i = v;
        host_wr_n_i = 0;
        @(negedge clk_i);
        host_wr_n_i = 1;
    endtask
    // data is the value loaded at the taking edge, before side effects land
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(negedge clk_i);
        host_addr_i = a;
        host_rd_n_i = 0;
        @(negedge clk_i);
        v = host_data_o;
        host_rd_n_i = 1;
    endtask
    task automatic rc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(v & m, exp);
    endtask
    task automatic t_reset;
        check({bus_oe, pulse_n, auto_n, rst_n, choose_n, irq_oe, hoe}, 8'h74);
        check(bus_o, 8'hff);
        rc(PPF_OFS_CTRL, 8'hff, 8'he0);
        rc(PPF_OFS_ALT, 8'hff, 8'h80);
        wr(PPF_OFS_CTRL, 8'h0e);
        check({auto_n, rst_n, choose_n}, 8'h02);
        rc(PPF_OFS_CTRL, 8'hff, 8'hee);
        rc(PPF_OFS_STAT, 8'h3b, 8'h2b);
        $display("test reset done");
    endtask
    task automatic t_fifo;
        stall = 1;
        wr(PPF_OFS_CTRL, 8'h05);
        rc(PPF_OFS_STAT, 8'h80, 8'h00);
        rc(PPF_OFS_CTRL, 8'hff, 8'he5);
        wr(PPF_OFS_CTRL, 8'h04);
        stall = 0;
        repeat (20) @(negedge clk_i);
        rc(PPF_OFS_STAT, 8'h04, 8'h00);
        rc(PPF_OFS_STAT, 8'h04, 8'h04);
        wr(PPF_OFS_ALT, 8'h84);
        stall = 1;
        wr(PPF_OFS_CTRL, 8'h05);
        wr(PPF_OFS_CTRL, 8'h04);
        stall = 0;
        repeat (20) @(negedge clk_i);
        stall = 1;
        n0 = printer.n_rx;
        for (int k = 0; k < 3; k++) wr(PPF_OFS_DATA, 8'ha1 + 8'(k) * 8'h11);
        repeat (30) @(negedge clk_i);
        rc(PPF_OFS_ALT, 8'hff, 8'h03);
        rc(PPF_OFS_STAT, 8'h80, 8'h80);
        wr(PPF_OFS_CTRL, 8'h05);
        check(pulse_n, 8'h01);
        wr(PPF_OFS_CTRL, 8'h04);
        check(printer.width, 8'h02);
        stall = 0;
        repeat (100) @(negedge clk_i);
        rc(PPF_OFS_ALT, 8'hff, 8'h00);
        for (int k = 0; k < 3; k++) begin
            check(printer.rx[n0 + 4'(k)], 8'ha1 + 8'(k) * 8'h11);
        end
        $display("test fifo done");
    endtask
    task automatic t_full;
        wr(PPF_OFS_CTRL, 8'h00);
        wr(PPF_OFS_ALT, 8'ha4);
        for (int i = 0; i < 84; i++) wr(PPF_OFS_DATA, 8'(i));
        repeat (6) @(negedge clk_i);
        rc(PPF_OFS_ALT, 8'hff, 8'h53);
        rc(PPF_OFS_STAT, 8'hc0, 8'h40);
        check(irq_n, 8'h00);
        for (int i = 0; i < 83; i++) begin
            rc(PPF_OFS_DATA, 8'hff, 8'(i));
            check(pulse_n, 8'h01);
            repeat (6) @(negedge clk_i);
        end
        rc(PPF_OFS_ALT, 8'hff, 8'h00);
        wr(PPF_OFS_ALT, 8'hb4);
        rc(PPF_OFS_STAT, 8'h43, 8'h40);
        check(irq_n, 8'h00);
        for (int i = 0; i < 5; i++) wr(PPF_OFS_DATA, 8'(i));
        wr(PPF_OFS_CTRL, 8'h04);
        repeat (4) @(negedge clk_i);
        rc(PPF_OFS_ALT, 8'hff, 8'h00);
        wr(PPF_OFS_ALT, 8'h00);
        $display("test full done");
    endtask
    task automatic t_irq;
        wr(PPF_OFS_CTRL, 8'h15);
        check({irq_oe, irq_n}, 8'h02);
        wr(PPF_OFS_DATA, 8'h55);
        check(irq_n, 8'h01);
        irq_style_pin_i = 1;
        wr(PPF_OFS_CTRL, 8'h15);
        wr(PPF_OFS_CTRL, 8'h14);
        wr(PPF_OFS_DATA, 8'h55);
        check(irq_n, 8'h00);
        rd(PPF_OFS_STAT, d);
        repeat (2) @(negedge clk_i);
        check(irq_n, 8'h01);
        wr(PPF_OFS_ALT, 8'h40);
        wr(PPF_OFS_CTRL, 8'h15);
        check(irq_n, 8'h01);
        rd(PPF_OFS_STAT, d);
        repeat (2) @(negedge clk_i);
        check(irq_n, 8'h00);
        wr(PPF_OFS_ALT, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_dir;
        wr(PPF_OFS_CTRL, 8'h24);
        check(bus_oe, 8'h00);
        rc(PPF_OFS_DATA, 8'hff, 8'h3c);
        wr(PPF_OFS_CTRL, 8'h04);
        dir_hw_select_i = 0;
        wr(PPF_OFS_STAT, PPF_DIR_IN_CODE);
        wr(PPF_OFS_STAT, 8'h12);
        check(bus_oe, 8'h00);
        wr(PPF_OFS_STAT, PPF_DIR_OUT_CODE);
        wr(PPF_OFS_DATA, 8'h96);
        check({7'h0, bus_oe} + bus_o, 8'h97);
        // a write while the enable is low must leave no trace
        ce = 0;
        wr(PPF_OFS_DATA, 8'h11);
        ce = 1;
        repeat (2) @(negedge clk_i);
        check(bus_o, 8'h96);
        $display("test dir done");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (8) @(negedge clk_i);
        sys_rst_i = 0;
        t_reset();
        t_fifo();
        t_full();
        t_irq();
        t_dir();
        stop_test();
    end
endmodule // test_ppf_port
